// File: design/adc_pkg.sv
// Shared constants, pin bundle and result folding for the converter read port.
// Assumes a single 40 MHz clock; host pins are asynchronous to it.
package adc_pkg;

  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          CONV_TIME_NS    = 700;
  localparam int          ABORT_MIN_NS    = 60;
  localparam int          ABORT_MAX_NS    = 600;
  localparam int          FOLD_SPACING_NS = 50;

  // Longest times round down, least times round up
  localparam int          CONV_CYC        = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int          ABORT_MIN_CYC   = (ABORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ABORT_MAX_CYC   = ABORT_MAX_NS / CLK_PERIOD_NS;
  localparam int          FOLD_SPACING_CYC =
    (FOLD_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int          RESULT_W        = 16;
  localparam int          CNT_W           = 5;
  localparam int          FOLD_HI_LSB     = 10;
  localparam int          FOLD_SRC_MSB    = 7;
  localparam int          FOLD_SRC_LSB    = 2;

  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [RESULT_W-1:0] MSB_MASK   = 16'h8000;
  localparam logic [FOLD_HI_LSB-1:0] FOLD_ONES = 10'h3ff;

  typedef struct packed {
    logic convert_start_n;  // Falling edge holds and starts a conversion
    logic cs_n;             // Chip select, falling edge starts acquisition
    logic rd_n;             // Read strobe, output enable while low together with cs_n
    logic byte_sel;         // 1 folds result bits 7:2 onto the upper pins
  } host_pins_t;

  localparam host_pins_t PINS_IDLE = '{convert_start_n: 1'b1, cs_n: 1'b1,
                                       rd_n: 1'b1, byte_sel: 1'b0};

  function automatic logic [RESULT_W-1:0] fold_word(input logic [RESULT_W-1:0] w,
                                                    input logic sel);
    fold_word = sel ? {w[FOLD_SRC_MSB:FOLD_SRC_LSB], FOLD_ONES} : w;
  endfunction : fold_word

endpackage : adc_pkg

// File: design/sar_engine.sv
// Successive-approximation engine: one trial bit per clock, fixed conversion length.
// Assumes start and abort are single-cycle pulses from the read port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
  input  wire logic                         clock,    // 40 MHz clock
  input  wire logic                         rst,      // Async reset, high
  input  wire logic                         start,    // Pulse: hold sample, begin
  input  wire logic                         abort,    // Pulse: drop conversion
  input  wire logic [adc_pkg::RESULT_W-1:0] sample,   // Front-end code to hold
  output logic      [adc_pkg::CNT_W-1:0]    elapsed,  // Cycles since start
  output logic                              done,     // Pulse: code is final
  output logic      [adc_pkg::RESULT_W-1:0] code      // Resolved code
);

  logic                         running_q;
  logic [adc_pkg::CNT_W-1:0]    elapsed_q;
  logic [adc_pkg::RESULT_W-1:0] mask_q;
  logic [adc_pkg::RESULT_W-1:0] held_q;
  logic [adc_pkg::RESULT_W-1:0] code_q;
  logic [adc_pkg::RESULT_W-1:0] trial;

  assign trial   = code_q | mask_q;
  assign elapsed = elapsed_q;
  assign code    = code_q;
  assign done    = running_q && !abort &&
                   (elapsed_q == adc_pkg::CNT_W'(adc_pkg::CONV_CYC - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      running_q <= 1'b0;
    end else if (start) begin
      running_q <= 1'b1;
    end else if (abort || done) begin
      running_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      elapsed_q <= '0;
    end else if (start) begin
      elapsed_q <= '0;
    end else if (running_q) begin
      elapsed_q <= elapsed_q + 1'b1;
    end
  end

  // Held sample stays frozen for the whole conversion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held_q <= adc_pkg::RESULT_RST;
    end else if (start) begin
      held_q <= sample;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
      code_q <= adc_pkg::RESULT_RST;
    end else if (start) begin
      mask_q <= adc_pkg::MSB_MASK;
      code_q <= adc_pkg::RESULT_RST;
    end else if (running_q && mask_q != '0) begin
      mask_q <= mask_q >> 1;
      code_q <= (trial <= held_q) ? trial : code_q;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  code_final_a: assert property (done |-> code_q == held_q)
    else $error("Conversion finished with unresolved code");

endmodule : sar_engine
`default_nettype wire

// File: design/sar_adc_parallel_read_port.sv
// Digital control and parallel read port of a 16-bit SAR converter.
// Assumes host strobes arrive asynchronously; analog_code comes from a front end on clock.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_read_port (
  input  wire logic                         clock,              // 40 MHz clock
  input  wire logic                         rst,                // Async reset, high
  input  wire adc_pkg::host_pins_t          host_pins,          // Raw host pins
  input  wire logic [adc_pkg::RESULT_W-1:0] analog_code,        // Front-end code
  output logic                              busy,               // Conversion running
  output logic                              tracking,           // Acquisition phase
  output logic      [adc_pkg::RESULT_W-1:0] result_bus_out,     // Data pins, value
  output logic                              result_bus_oe,      // Data pins, enable
  output logic                              result_bus_msb_pin  // Copy of top pin
);

  typedef enum logic {ST_ACQ, ST_CONV} conv_state_t;

  adc_pkg::host_pins_t          pin_s1_q;
  adc_pkg::host_pins_t          pin_s2_q;
  adc_pkg::host_pins_t          pin_prev_q;
  conv_state_t                  state_q;
  conv_state_t                  state_d;
  logic                         busy_q;
  logic                         track_q;
  logic                         oe_q;
  logic [adc_pkg::RESULT_W-1:0] result_q;
  logic [adc_pkg::RESULT_W-1:0] bus_q;
  logic [adc_pkg::RESULT_W-1:0] word_d;
  logic                         cv_fall;
  logic                         cs_fall;
  logic                         start;
  logic                         abort_edge;
  logic                         in_window;
  logic                         abort_ok;
  logic [adc_pkg::CNT_W-1:0]    elapsed;
  logic                         eng_done;
  logic [adc_pkg::RESULT_W-1:0] eng_code;

  // Two-flop synchronisers; edges are found on the second stage only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_q   <= adc_pkg::PINS_IDLE;
      pin_s2_q   <= adc_pkg::PINS_IDLE;
      pin_prev_q <= adc_pkg::PINS_IDLE;
    end else begin
      pin_s1_q   <= host_pins;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  assign cv_fall = pin_prev_q.convert_start_n && !pin_s2_q.convert_start_n;
  assign cs_fall = pin_prev_q.cs_n && !pin_s2_q.cs_n;

  assign start      = (state_q == ST_ACQ) && cv_fall;
  assign abort_edge = (cv_fall && !pin_s2_q.cs_n) || cs_fall;
  // Abort edges outside the window are ignored so a late glitch cannot
  // throw away a nearly finished result
  assign in_window  = (elapsed >= adc_pkg::CNT_W'(adc_pkg::ABORT_MIN_CYC - 1)) &&
                      (elapsed <= adc_pkg::CNT_W'(adc_pkg::ABORT_MAX_CYC - 1));
  assign abort_ok   = (state_q == ST_CONV) && abort_edge && in_window;

  sar_engine u_engine (
    .clock   (clock),
    .rst     (rst),
    .start   (start),
    .abort   (abort_ok),
    .sample  (analog_code),
    .elapsed (elapsed),
    .done    (eng_done),
    .code    (eng_code)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ACQ: begin
        if (start) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort_ok || eng_done) begin
          state_d = ST_ACQ;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_ACQ;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d == ST_CONV);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      track_q <= 1'b0;
    end else if (cs_fall) begin
      track_q <= 1'b1;
    end else if (start) begin
      track_q <= 1'b0;
    end
  end

  // Aborted conversions leave the previous result in place
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result_q <= adc_pkg::RESULT_RST;
    end else if (eng_done) begin
      result_q <= eng_code;
    end
  end

  // Bus follows the fresh code in the same edge busy falls, so no lag after busy
  assign word_d = eng_done ? eng_code : result_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_q <= adc_pkg::RESULT_RST;
    end else begin
      bus_q <= adc_pkg::fold_word(word_d, pin_s2_q.byte_sel);
    end
  end

  // Chip select frames the read; either strobe high releases the pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !pin_s2_q.rd_n && !pin_s2_q.cs_n;
    end
  end

  assign busy               = busy_q;
  assign tracking           = track_q;
  assign result_bus_out     = bus_q;
  assign result_bus_oe      = oe_q;
  assign result_bus_msb_pin = bus_q[adc_pkg::RESULT_W-1];

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  conv_start_a: assert property (start && !cs_fall |=> busy_q && !track_q)
    else $error("Convert start did not raise busy");

  busy_bound_a: assert property ($rose(busy_q) |-> busy_q[*3] ##[0:26] !busy_q)
    else $error("Busy width outside conversion length");

  abort_drop_a: assert property (abort_ok |=> !busy_q && state_q == ST_ACQ)
    else $error("Abort edge did not end conversion");

  msb_ready_a: assert property ($fell(busy_q) && !$past(abort_ok) && !$past(pin_s2_q.byte_sel)
                                |-> bus_q == result_q)
    else $error("Result not on bus when busy fell");

  unfolded_a: assert property (!$past(pin_s2_q.byte_sel) && $stable(result_q)
                               |-> bus_q == result_q)
    else $error("Unfolded bus differs from result");

  folded_a: assert property ($past(pin_s2_q.byte_sel) && $stable(result_q)
                             |-> bus_q == {result_q[7:2], 10'h3ff})
    else $error("Folded bus layout wrong");

  oe_on_a: assert property (!pin_s2_q.rd_n && !pin_s2_q.cs_n |=> oe_q)
    else $error("Outputs not enabled during read");

  oe_off_a: assert property (pin_s2_q.rd_n || pin_s2_q.cs_n |=> !oe_q)
    else $error("Bus not released after read");

  track_on_a: assert property (cs_fall |=> track_q)
    else $error("Chip select fall did not start acquisition");

  track_hold_a: assert property (!cs_fall && !start |=> $stable(track_q))
    else $error("Acquisition flag moved without an edge");

  busy_cause_a: assert property ($rose(busy_q) |-> $past(start))
    else $error("Busy rose without a convert start");

  done_drop_a: assert property (eng_done |=> !busy_q && result_q == $past(eng_code))
    else $error("Finished conversion left busy high");

  abort_keep_a: assert property (abort_ok |=> $stable(result_q))
    else $error("Aborted conversion changed the result");

  read_prev_a: assert property (oe_q && busy_q && !$past(pin_s2_q.byte_sel)
                                |-> bus_q == result_q)
    else $error("Read during conversion lost previous result");

  msb_pin_a: assert property ($fell(busy_q) && !$past(abort_ok) && !$past(pin_s2_q.byte_sel)
                              |-> result_bus_msb_pin == result_q[adc_pkg::RESULT_W-1])
    else $error("Top data pin not valid when busy fell");

  // Abort decode is checked per source, since the chip-select edge alone ends a conversion but convert-start only with cs_n low,
  // and a refused edge must leave the conversion running to its full length
  cs_abort_a: assert property (state_q == ST_CONV && cs_fall && in_window |=> !busy_q)
    else $error("Chip select fall did not abort");

  cv_abort_a: assert property (state_q == ST_CONV && cv_fall && !pin_s2_q.cs_n && in_window
                               |=> !busy_q)
    else $error("Second convert start did not abort");

  cv_refused_a: assert property (state_q == ST_CONV && cv_fall && pin_s2_q.cs_n && !cs_fall
                                 && !eng_done |=> busy_q)
    else $error("Deselected convert start ended conversion");

endmodule : sar_adc_parallel_read_port
`default_nettype wire

// File: verification/host_model.sv
// Host side of the converter: drives convert-start, chip select, read strobe, fold select.
// Assumes the caller runs tasks one at a time per pin; pins move 2 ns after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic           clock, // Bench clock
  output var adc_pkg::host_pins_t pins   // Host pins to the converter
);
  initial pins = adc_pkg::PINS_IDLE;

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step

  task automatic pulse_start;
    step(1);
    pins.convert_start_n = 1'b0;
    step(2);
    pins.convert_start_n = 1'b1;
  endtask : pulse_start

  task automatic pulse_cs;
    step(1);
    pins.cs_n = 1'b1;
    step(2);
    pins.cs_n = 1'b0;
  endtask : pulse_cs

  task automatic set_cs(input logic v);
    step(1);
    pins.cs_n = v;
  endtask : set_cs

  // Read may begin in the cycle busy falls, no wait
  task automatic read(input logic sel, input logic by_cs);
    step(1);
    pins.byte_sel = sel; // Settles 3 cycles before the strobe, 6 when chip select frames the read
    step(3);
    if (by_cs) begin
      pins.cs_n = 1'b1;
      step(3);
      pins.rd_n = 1'b0;
      pins.cs_n = 1'b0;
    end else begin
      pins.rd_n = 1'b0;
    end
    step(5);
    if (by_cs) pins.cs_n = 1'b1; // Chip select alone frames this read
    else pins.rd_n = 1'b1;
    step(4);
    pins.rd_n = 1'b1;
    step(1);
    pins.cs_n = 1'b0;
  endtask : read
endmodule : host_model
`default_nettype wire

// File: verification/tb_sar_adc_parallel_read_port.sv
// Self-checking bench: host model drives pins, queue of expected bus words per read.
// Assumes result equals the held front-end code; chip select normally rests low.
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_parallel_read_port;
  logic                clock;
  logic                rst;
  adc_pkg::host_pins_t pins;
  logic [15:0]         analog_code;
  logic                busy;
  logic                tracking;
  logic [15:0]         bus_out;
  logic                oe;
  logic                msb;
  logic                oe_d;
  logic [15:0]         last;
  logic [15:0]         e;
  logic [31:0]         rng;
  logic [15:0]         exp_q[$];
  int                  err_total;
  int                  checks;

  host_model host (.clock(clock), .pins(pins));

  sar_adc_parallel_read_port uut (
    .clock(clock), .rst(rst), .host_pins(pins), .analog_code(analog_code), .busy(busy),
    .tracking(tracking), .result_bus_out(bus_out), .result_bus_oe(oe),
    .result_bus_msb_pin(msb));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [15:0] rnd16();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0];
  endfunction : rnd16

  task automatic cmp_word(input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (exp !== got) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_cnt(input int exp, input int got);
    checks++;
    if (exp != got) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp_cnt

  task automatic print_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Oldest note is matched against each new bus enable
  always @(negedge clock) begin
    if (oe === 1'b1 && oe_d !== 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx;
      cmp_word(e, bus_out);
      cmp_word({15'h0, e[15]}, {15'h0, msb});
    end
    oe_d = oe;
  end

  // Modes: 0 plain with read, 1 cs abort, 2 start abort, 3 start ignored with cs high
  task automatic conv(input int mode);
    logic [15:0] code;
    int          n;
    int          rise;
    int          fall;
    code = rnd16();
    rise = 0;
    fall = 0;
    if (mode == 3) host.set_cs(1'b1);
    analog_code = code;
    fork host.pulse_start(); join_none
    for (n = 1; n <= 60 && fall == 0; n++) begin
      @(negedge clock);
      if (rise == 0 && busy === 1'b1) begin
        rise = n;
        fork begin @(posedge clock); #2; analog_code = rnd16(); end join_none
      end
      if (rise != 0 && busy === 1'b0) fall = n;
      if (rise != 0 && n == rise + 10) begin
        case (mode)
          0: begin
            exp_q.push_back(last);
            fork host.read(1'b0, 1'b0); join_none
          end
          1: fork host.pulse_cs(); join_none
          default: fork host.pulse_start(); join_none
        endcase
      end
    end
    cmp_cnt(1, int'(rise != 0 && rise <= 5));
    if (mode == 0 || mode == 3) begin
      cmp_cnt(rise + adc_pkg::CONV_CYC, fall);
      last = code;
    end else begin
      // Abort seen 4 cycles after the start pulse task, 6 after the chip-select pulse
      cmp_cnt(rise + ((mode == 1) ? 16 : 14), fall);
    end
    cmp_word({15'h0, mode == 1}, {15'h0, tracking});
    if (mode == 3) host.set_cs(1'b0);
    exp_q.push_back(last);
    host.read(1'b0, 1'b0);
    cmp_word(16'h0, {15'h0, oe});
    exp_q.push_back({last[7:2], 10'h3ff});
    host.read(1'b1, 1'b0);
    exp_q.push_back(last);
    host.read(1'b0, 1'b1);
    cmp_word(16'h0, {15'h0, oe});
  endtask : conv

  initial begin
    rst = 1'b1;
    analog_code = 16'h0000;
    rng = 32'h4076fbf9;
    err_total = 0;
    checks = 0;
    last = 16'h0000;
    repeat (20) @(posedge clock);
    #2;
    rst = 1'b0;
    host.set_cs(1'b0);
    for (int i = 0; i < 8; i++) conv(i % 4);
    cmp_cnt(0, exp_q.size());
    print_verdict();
  end

  initial begin
    #100us;
    err_total++;
    print_verdict();
  end
endmodule : tb_sar_adc_parallel_read_port
`default_nettype wire
